// file: verilog/tap_pkg.sv
package tap_pkg;

    // -------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // -------------------------------------------------------------------
    localparam logic [7:0] REG_MISC     = 8'h02;
    localparam logic [7:0] REG_SEL      = 8'h03;
    localparam logic [7:0] REG_ADDR_HI  = 8'h04;
    localparam logic [7:0] REG_ADDR_LO  = 8'h05;
    localparam logic [7:0] REG_WIN      = 8'h06;
    localparam logic [7:0] REG_EDGE     = 8'h08;
    localparam logic [7:0] REG_IRQ_ST   = 8'h09;
    localparam logic [7:0] REG_IRQ_MASK = 8'h0a;

    // -------------------------------------------------------------------
    // Field codes and positions
    // -------------------------------------------------------------------
    localparam logic [1:0] TGT_OFFSET   = 2'h0;
    localparam logic [1:0] TGT_GAIN     = 2'h1;
    localparam logic [1:0] TGT_GAMMA    = 2'h2;
    localparam logic [1:0] TGT_NONE     = 2'h3;
    localparam logic [1:0] COLOR_NONE   = 2'h3;
    localparam int         SEL_PAUSE    = 4;
    localparam int         SEL_DRAM     = 6;
    localparam int         ADDR_DIR     = 6;
    localparam logic       DIR_READ     = 1'b1;
    localparam int         MISC_LSB     = 2;
    localparam int         IRQ_P_ENTER  = 0;
    localparam int         IRQ_P_EXIT   = 1;
    localparam int         IRQ_MISC_LSB = 2;
    localparam int         ADDR_W       = 14;
    localparam int         GAMMA_W      = 12;

    // -------------------------------------------------------------------
    // Reset values and bus answers
    // -------------------------------------------------------------------
    localparam logic [1:0]  RST_TARGET   = 2'h3;
    localparam logic [1:0]  RST_COLOR    = 2'h0;
    localparam logic [13:0] RST_ADDR     = 14'h0000;
    localparam logic [5:0]  RST_EDGE     = 6'h00;
    localparam logic [7:0]  RST_MASK     = 8'h00;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

endpackage : tap_pkg

// file: verilog/tap_table_port.sv
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/10ps
// What this block does
// - Input flags read their level; edge-sensitive flags latch rising edges, cleared by reading.
// - Read-only pause flag set while scanning is held by a full buffer.
// - Pause flag is high during the pause-and-reverse cycle, clears when it ends.
// - Target field picks offset 0, gain 1, gamma 2; code 3 selects nothing.
// - Gamma target uses addresses 0 to 4095.
// - Offset and gain use addresses 0 to 16383, split over high and low registers.
// - High address bit 6 sets direction: 1 read, 0 write, set before data.
// - Window accesses hit the current address in the selected table and color.
// - Address steps after each gamma byte and each coefficient byte pair.
module tap_table_port
(
    // Clock and reset
    input  wire logic        SYS_CLK,
    input  wire logic        SYS_RST,
    // AXI4-Lite write address and data
    input  wire logic [11:0] S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    // AXI4-Lite write response
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    // AXI4-Lite read
    input  wire logic [11:0] S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY,
    // Scanner side
    input  wire logic [5:0]  MISC_IN,
    input  wire logic        PAUSE_ENTER,
    input  wire logic        PAUSE_EXIT,
    // Interrupt
    output logic             IRQ
);

    // -------------------------------------------------------------------
    // State
    // -------------------------------------------------------------------
    typedef enum logic [1:0] {RD_IDLE, RD_WAIT, RD_RESP} tap_rd_state_t;

    typedef struct packed {
        logic          awready;
        logic          wready;
        logic          bvalid;
        logic [1:0]    bresp;
        logic          arready;
        logic          rvalid;
        logic [1:0]    rresp;
        logic [7:0]    rdata;
        tap_rd_state_t rd_state;
        logic [7:0]    rd_idx;
        logic [1:0]    target;
        logic [1:0]    color;
        logic          dram_test;
        logic          dir;
        logic [13:0]   addr;
        logic          phase;
        logic [7:0]    lo_byte;
        logic [5:0]    edge_cfg;
        logic [5:0]    edge_flag;
        logic [5:0]    sync1;
        logic [5:0]    sync2;
        logic [5:0]    sync3;
        logic          pause;
        logic [7:0]    irq_st;
        logic [7:0]    irq_mask;
        logic          irq;
    } tap_state_t;

    tap_state_t q;
    tap_state_t d;

    // Tables are too large for the state struct and have no reset
    logic [15:0] coef_mem [0:(1 << 17) - 1];
    logic [7:0]  gam_mem  [0:(1 << 14) - 1];
    logic [15:0] coef_rd_q;
    logic [7:0]  gam_rd_q;
    logic        coef_we;
    logic        gam_we;
    logic [15:0] coef_wdata;
    logic [16:0] coef_idx;
    logic [13:0] gam_idx;

    logic        wr_go;
    logic        rd_go;
    logic        ar_want;
    logic [7:0]  w_idx;
    logic        w_map;
    logic        w_lane;
    logic        tgt_ok;
    logic [5:0]  rise;
    logic [7:0]  misc_rd;

    function automatic logic fn_mapped(input logic [11:0] a);
        logic [7:0] i;
        i = a[9:2];
        fn_mapped = (a[11:10] == 2'h0) &&
                    (i == tap_pkg::REG_MISC || i == tap_pkg::REG_SEL ||
                     i == tap_pkg::REG_ADDR_HI || i == tap_pkg::REG_ADDR_LO ||
                     i == tap_pkg::REG_WIN || i == tap_pkg::REG_EDGE ||
                     i == tap_pkg::REG_IRQ_ST || i == tap_pkg::REG_IRQ_MASK);
    endfunction : fn_mapped

    // -------------------------------------------------------------------
    // Decode
    // -------------------------------------------------------------------
    // Reads and writes never overlap, so a window access never races
    // an address change or a table write.
    assign ar_want = S_AXI_ARVALID && !q.arready && q.rd_state == RD_IDLE &&
                     !q.awready && !q.bvalid;
    assign wr_go   = q.awready && S_AXI_AWVALID && q.wready && S_AXI_WVALID;
    assign rd_go   = q.arready && S_AXI_ARVALID;
    assign w_idx   = S_AXI_AWADDR[9:2];
    assign w_map   = fn_mapped(S_AXI_AWADDR);
    assign w_lane  = S_AXI_WSTRB[0];
    assign tgt_ok  = q.target != tap_pkg::TGT_NONE && q.color != tap_pkg::COLOR_NONE;
    assign rise    = q.sync2 & ~q.sync3;
    assign misc_rd = {(q.edge_cfg & q.edge_flag) | (~q.edge_cfg & q.sync2), 2'h0};

    assign coef_idx   = {q.target[0], q.color, q.addr};
    assign gam_idx    = {q.color, q.addr[tap_pkg::GAMMA_W-1:0]};
    assign coef_wdata = {S_AXI_WDATA[7:0], q.lo_byte};

    // -------------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------------
    always_comb
    begin
        d       = q;
        coef_we = 1'b0;
        gam_we  = 1'b0;
        d.sync1 = MISC_IN;
        d.sync2 = q.sync1;
        d.sync3 = q.sync2;

        d.arready = ar_want;
        d.awready = S_AXI_AWVALID && S_AXI_WVALID && !q.awready && !q.bvalid &&
                    q.rd_state == RD_IDLE && !q.arready && !ar_want;
        d.wready  = d.awready;

        if (q.bvalid && S_AXI_BREADY)
        begin
            d.bvalid = 1'b0;
        end

        d.edge_flag = q.edge_flag | (rise & q.edge_cfg);
        d.pause     = PAUSE_ENTER | (q.pause & ~PAUSE_EXIT);
        d.irq_st    = q.irq_st;

        // Register writes
        if (wr_go)
        begin
            d.bvalid = 1'b1;
            d.bresp  = w_map ? tap_pkg::RESP_OKAY : tap_pkg::RESP_SLVERR;
            if (w_map && w_lane)
            begin
                case (w_idx)
                    tap_pkg::REG_SEL:
                    begin
                        d.target    = S_AXI_WDATA[1:0];
                        d.color     = S_AXI_WDATA[3:2];
                        d.dram_test = S_AXI_WDATA[tap_pkg::SEL_DRAM];
                        d.phase     = 1'b0;
                    end
                    tap_pkg::REG_ADDR_HI:
                    begin
                        d.addr[13:8] = S_AXI_WDATA[5:0];
                        d.dir        = S_AXI_WDATA[tap_pkg::ADDR_DIR];
                        d.phase      = 1'b0;
                    end
                    tap_pkg::REG_ADDR_LO:
                    begin
                        d.addr[7:0] = S_AXI_WDATA[7:0];
                        d.phase     = 1'b0;
                    end
                    tap_pkg::REG_WIN:
                    begin
                        // Writes while reading is selected are dropped
                        if (q.dir != tap_pkg::DIR_READ && tgt_ok)
                        begin
                            if (q.target == tap_pkg::TGT_GAMMA)
                            begin
                                gam_we = 1'b1;
                                d.addr = q.addr + 14'h0001;
                            end
                            else if (!q.phase)
                            begin
                                d.lo_byte = S_AXI_WDATA[7:0];
                                d.phase   = 1'b1;
                            end
                            else
                            begin
                                coef_we = 1'b1;
                                d.phase = 1'b0;
                                d.addr  = q.addr + 14'h0001;
                            end
                        end
                    end
                    tap_pkg::REG_EDGE:
                    begin
                        d.edge_cfg = S_AXI_WDATA[5:0];
                    end
                    tap_pkg::REG_IRQ_ST:
                    begin
                        d.irq_st = q.irq_st & ~S_AXI_WDATA[7:0];
                    end
                    tap_pkg::REG_IRQ_MASK:
                    begin
                        d.irq_mask = S_AXI_WDATA[7:0];
                    end
                    default:
                    begin
                        d.irq_mask = q.irq_mask;
                    end
                endcase
            end
        end

        // Register reads
        case (q.rd_state)
            RD_IDLE:
            begin
                if (rd_go)
                begin
                    d.rd_idx   = fn_mapped(S_AXI_ARADDR) ? S_AXI_ARADDR[9:2] : 8'hff;
                    d.rd_state = RD_WAIT;
                end
            end
            RD_WAIT:
            begin
                // Table read data is one cycle behind the address
                d.rd_state = RD_RESP;
                d.rvalid   = 1'b1;
                d.rresp    = tap_pkg::RESP_OKAY;
                d.rdata    = 8'h00;
                case (q.rd_idx)
                    tap_pkg::REG_MISC:
                    begin
                        d.rdata     = misc_rd;
                        // Clearing every bit keeps a stale flag from coming back when
                        // its input is made edge sensitive again later
                        d.edge_flag = rise & q.edge_cfg;
                    end
                    tap_pkg::REG_SEL:
                        d.rdata = {1'b0, q.dram_test, 1'b0, q.pause, q.color, q.target};
                    tap_pkg::REG_ADDR_HI:
                        d.rdata = {1'b0, q.dir, q.addr[13:8]};
                    tap_pkg::REG_ADDR_LO:
                        d.rdata = q.addr[7:0];
                    tap_pkg::REG_WIN:
                    begin
                        if (q.dir == tap_pkg::DIR_READ && tgt_ok)
                        begin
                            if (q.target == tap_pkg::TGT_GAMMA)
                            begin
                                d.rdata = gam_rd_q;
                                d.addr  = q.addr + 14'h0001;
                            end
                            else if (!q.phase)
                            begin
                                d.rdata = coef_rd_q[7:0];
                                d.phase = 1'b1;
                            end
                            else
                            begin
                                d.rdata = coef_rd_q[15:8];
                                d.phase = 1'b0;
                                d.addr  = q.addr + 14'h0001;
                            end
                        end
                    end
                    tap_pkg::REG_EDGE:
                        d.rdata = {2'h0, q.edge_cfg};
                    tap_pkg::REG_IRQ_ST:
                        d.rdata = q.irq_st;
                    tap_pkg::REG_IRQ_MASK:
                        d.rdata = q.irq_mask;
                    default:
                        d.rresp = tap_pkg::RESP_SLVERR;
                endcase
            end
            RD_RESP:
            begin
                if (S_AXI_RREADY)
                begin
                    d.rvalid   = 1'b0;
                    d.rd_state = RD_IDLE;
                end
            end
            default:
                d.rd_state = RD_IDLE;
        endcase

        // New events win over a same-cycle clear
        d.irq_st[tap_pkg::IRQ_P_ENTER] = d.irq_st[tap_pkg::IRQ_P_ENTER] | PAUSE_ENTER;
        d.irq_st[tap_pkg::IRQ_P_EXIT]  = d.irq_st[tap_pkg::IRQ_P_EXIT] | PAUSE_EXIT;
        d.irq_st[7:tap_pkg::IRQ_MISC_LSB] = d.irq_st[7:tap_pkg::IRQ_MISC_LSB] |
                                            (rise & q.edge_cfg);
        d.irq = |(d.irq_st & d.irq_mask);
    end

    // -------------------------------------------------------------------
    // Registers and tables
    // -------------------------------------------------------------------
    always_ff @(posedge SYS_CLK)
    begin
        if (SYS_RST)
        begin
            q          <= '0;
            q.target   <= tap_pkg::RST_TARGET;
            q.color    <= tap_pkg::RST_COLOR;
            q.addr     <= tap_pkg::RST_ADDR;
            q.edge_cfg <= tap_pkg::RST_EDGE;
            q.irq_mask <= tap_pkg::RST_MASK;
        end
        else
        begin
            q <= d;
        end
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (coef_we)
        begin
            coef_mem[coef_idx] <= coef_wdata;
        end
        if (gam_we)
        begin
            gam_mem[gam_idx] <= S_AXI_WDATA[7:0];
        end
        coef_rd_q <= coef_mem[coef_idx];
        gam_rd_q  <= gam_mem[gam_idx];
    end

    assign S_AXI_AWREADY = q.awready;
    assign S_AXI_WREADY  = q.wready;
    assign S_AXI_BVALID  = q.bvalid;
    assign S_AXI_BRESP   = q.bresp;
    assign S_AXI_ARREADY = q.arready;
    assign S_AXI_RVALID  = q.rvalid;
    assign S_AXI_RRESP   = q.rresp;
    assign S_AXI_RDATA   = {24'h000000, q.rdata};
    assign IRQ           = q.irq;

    // -------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (SYS_RST);

    logic win_wr;
    logic misc_rd_go;
    assign win_wr     = wr_go && w_map && w_lane && w_idx == tap_pkg::REG_WIN;
    assign misc_rd_go = q.rd_state == RD_WAIT && q.rd_idx == tap_pkg::REG_MISC;

    sequence s_low_byte;
        win_wr && q.dir != tap_pkg::DIR_READ && tgt_ok &&
        q.target != tap_pkg::TGT_GAMMA && !q.phase;
    endsequence
    sequence s_high_byte;
        win_wr && q.dir != tap_pkg::DIR_READ && tgt_ok && q.phase;
    endsequence

    property p_edge_clear;
        misc_rd_go |=> ((q.edge_flag & ~$past(rise)) == 6'h00);
    endproperty
    a_edge_clear: assert property (p_edge_clear) else $error("edge flag kept after read");

    property p_pause_set;
        PAUSE_ENTER |=> q.pause && q.irq_st[tap_pkg::IRQ_P_ENTER];
    endproperty
    a_pause_set: assert property (p_pause_set) else $error("pause flag not set");

    property p_pause_end;
        (q.pause && PAUSE_EXIT && !PAUSE_ENTER) |=> !q.pause;
    endproperty
    a_pause_end: assert property (p_pause_end) else $error("pause flag not cleared");

    property p_no_target;
        (win_wr && q.target == tap_pkg::TGT_NONE) |=> $stable(q.addr) && $stable(q.phase);
    endproperty
    a_no_target: assert property (p_no_target) else $error("unselected target moved");

    property p_gamma_step;
        (win_wr && q.dir != tap_pkg::DIR_READ && tgt_ok && q.target == tap_pkg::TGT_GAMMA)
            |-> gam_we ##1 (q.addr == $past(q.addr) + 14'h0001);
    endproperty
    a_gamma_step: assert property (p_gamma_step) else $error("gamma byte did not step");

    property p_addr_lo;
        (wr_go && w_map && w_lane && w_idx == tap_pkg::REG_ADDR_LO)
            |=> q.addr[7:0] == $past(S_AXI_WDATA[7:0]) && $stable(q.addr[13:8]);
    endproperty
    a_addr_lo: assert property (p_addr_lo) else $error("low address not loaded");

    property p_dir_read_blocks;
        (win_wr && q.dir == tap_pkg::DIR_READ) |-> !coef_we && !gam_we ##1 $stable(q.addr);
    endproperty
    a_dir_read_blocks: assert property (p_dir_read_blocks) else $error("read-mode write");

    property p_pair_step;
        s_low_byte ##1 (!wr_go)[*1] ##[0:40] s_high_byte
            |=> q.addr == $past(q.addr) + 14'h0001 && !q.phase;
    endproperty
    a_pair_step: assert property (p_pair_step) else $error("pair did not step address");

    property p_pair_commit;
        s_high_byte and (q.target != tap_pkg::TGT_GAMMA)
            |-> coef_we && coef_wdata == {S_AXI_WDATA[7:0], q.lo_byte};
    endproperty
    a_pair_commit: assert property (p_pair_commit) else $error("pair not committed");

    property p_read_answer;
        rd_go |=> ##1 q.rvalid && q.rd_state == RD_RESP;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read answer late");

endmodule : tap_table_port

// file: verif/tb_table_access_port_status.sv
`timescale 1ns/10ps
module tb_table_access_port_status;

    // ----------------------------------------
    // Design hookup
    // ----------------------------------------
    logic        clk, rst, irq, pause_enter, pause_exit;
    logic [11:0] awaddr, araddr;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic [5:0]  misc_in, lvl;
    int          n_fail, n_compared;
    integer      seed;

    tap_table_port i_tap_table_port (.SYS_CLK(clk), .SYS_RST(rst),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
        .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .MISC_IN(misc_in),
        .PAUSE_ENTER(pause_enter), .PAUSE_EXIT(pause_exit), .IRQ(irq));

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ----------------------------------------
    // Checks and bus cycles
    // ----------------------------------------
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
        logic aw_done, w_done;
        aw_done = 1'b0;
        w_done  = 1'b0;
        @(posedge clk);
        awaddr  <= {2'h0, idx, 2'h0};
        wdata   <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!(aw_done && w_done))
        begin
            @(posedge clk);
            if (awready === 1'b1)
            begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (wready === 1'b1)
            begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        while (bvalid !== 1'b1) @(posedge clk);
        bready <= 1'b0;
        check($sformatf("bresp at %h", idx), {30'h0, er}, {30'h0, bresp});
    endtask : wr

    task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input logic [1:0] er);
        @(posedge clk);
        araddr  <= {2'h0, idx, 2'h0};
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge clk);
        rready <= 1'b0;
        check($sformatf("rdata at %h", idx), {24'h0, exp}, rdata);
        check($sformatf("rresp at %h", idx), {30'h0, er}, {30'h0, rresp});
    endtask : rd

    function automatic logic [7:0] hi_byte(input logic [13:0] a, input logic dir);
        return {1'b0, dir, a[13:8]};
    endfunction : hi_byte

    task automatic set_addr(input logic [13:0] a, input logic dir);
        wr(tap_pkg::REG_ADDR_HI, hi_byte(a, dir), tap_pkg::RESP_OKAY);
        wr(tap_pkg::REG_ADDR_LO, a[7:0], tap_pkg::RESP_OKAY);
    endtask : set_addr

    // Runs up to the top legal address so the step past the limit is seen too
    task automatic table_run(input logic [1:0] tgt);
        logic [7:0]  mem [8];
        logic [1:0]  col;
        logic [13:0] a0, a1;
        int          nb;
        col = 2'($unsigned($random(seed)) % 3);
        nb  = (tgt == tap_pkg::TGT_GAMMA) ? 4 : 8;
        a0  = (tgt == tap_pkg::TGT_GAMMA) ? 14'd4092 : 14'd16380;
        a1  = a0 + 14'd4;
        for (int i = 0; i < 8; i++) mem[i] = 8'($random(seed));
        wr(tap_pkg::REG_SEL, {4'h0, col, tgt}, tap_pkg::RESP_OKAY);
        set_addr(a0, 1'b0);
        for (int i = 0; i < nb; i++) wr(tap_pkg::REG_WIN, mem[i], tap_pkg::RESP_OKAY);
        rd(tap_pkg::REG_ADDR_HI, hi_byte(a1, 1'b0), tap_pkg::RESP_OKAY);
        rd(tap_pkg::REG_ADDR_LO, a1[7:0], tap_pkg::RESP_OKAY);
        set_addr(a0, 1'b1);
        wr(tap_pkg::REG_WIN, ~mem[0], tap_pkg::RESP_OKAY);
        for (int i = 0; i < nb; i++) rd(tap_pkg::REG_WIN, mem[i], tap_pkg::RESP_OKAY);
        rd(tap_pkg::REG_ADDR_LO, a1[7:0], tap_pkg::RESP_OKAY);
        $display("test table target %0d color %0d done", tgt, col);
    endtask : table_run

    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : close_out

    initial
    begin
        #(20 * 5000);
        n_fail++;
        $display("BAD watchdog expected done seen timeout");
        close_out();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        seed = 32'h353c;
        {awaddr, araddr, wdata, misc_in} = '0;
        {awvalid, wvalid, bready, arvalid, rready, pause_enter, pause_exit} = '0;
        wstrb = 4'h1;
        n_fail = 0;
        n_compared = 0;
        rst = 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rd(tap_pkg::REG_SEL, 8'h03, tap_pkg::RESP_OKAY);
        rd(tap_pkg::REG_ADDR_HI, 8'h00, tap_pkg::RESP_OKAY);
        rd(tap_pkg::REG_ADDR_LO, 8'h00, tap_pkg::RESP_OKAY);
        rd(tap_pkg::REG_EDGE, 8'h00, tap_pkg::RESP_OKAY);
        rd(tap_pkg::REG_IRQ_MASK, 8'h00, tap_pkg::RESP_OKAY);
        wr(8'h3f, 8'h55, tap_pkg::RESP_SLVERR);
        rd(8'h3f, 8'h00, tap_pkg::RESP_SLVERR);
        $display("test reset and unmapped done");
        for (int t = 0; t < 3; t++) table_run(2'(t));
        table_run(tap_pkg::TGT_OFFSET);
        // No target: window traffic is answered but moves nothing; test bit is only stored
        wr(tap_pkg::REG_SEL, 8'h43, tap_pkg::RESP_OKAY);
        set_addr(14'h0000, 1'b0);
        wr(tap_pkg::REG_WIN, 8'h5a, tap_pkg::RESP_OKAY);
        rd(tap_pkg::REG_ADDR_LO, 8'h00, tap_pkg::RESP_OKAY);
        set_addr(14'h0000, 1'b1);
        rd(tap_pkg::REG_WIN, 8'h00, tap_pkg::RESP_OKAY);
        wr(tap_pkg::REG_IRQ_MASK, 8'h01, tap_pkg::RESP_OKAY);
        wstrb <= 4'h0;
        wr(tap_pkg::REG_IRQ_MASK, 8'hfe, tap_pkg::RESP_OKAY);
        wstrb <= 4'h1;
        rd(tap_pkg::REG_IRQ_MASK, 8'h01, tap_pkg::RESP_OKAY);
        @(posedge clk) pause_enter <= 1'b1;
        @(posedge clk) pause_enter <= 1'b0;
        rd(tap_pkg::REG_SEL, 8'h53, tap_pkg::RESP_OKAY);
        check("irq after pause", 32'h1, {31'h0, irq});
        @(posedge clk) pause_exit <= 1'b1;
        @(posedge clk) pause_exit <= 1'b0;
        rd(tap_pkg::REG_SEL, 8'h43, tap_pkg::RESP_OKAY);
        rd(tap_pkg::REG_IRQ_ST, 8'h03, tap_pkg::RESP_OKAY);
        wr(tap_pkg::REG_IRQ_ST, 8'h01, tap_pkg::RESP_OKAY);
        rd(tap_pkg::REG_IRQ_ST, 8'h02, tap_pkg::RESP_OKAY);
        check("irq after clear", 32'h0, {31'h0, irq});
        $display("test pause and interrupt done");
        lvl = 6'($random(seed));
        @(posedge clk) misc_in <= lvl;
        repeat (6) @(posedge clk);
        rd(tap_pkg::REG_MISC, {lvl, 2'h0}, tap_pkg::RESP_OKAY);
        wr(tap_pkg::REG_EDGE, 8'h01, tap_pkg::RESP_OKAY);
        @(posedge clk) misc_in <= {lvl[5:1], 1'b0};
        repeat (5) @(posedge clk);
        misc_in <= {lvl[5:1], 1'b1};
        repeat (5) @(posedge clk);
        misc_in <= {lvl[5:1], 1'b0};
        repeat (5) @(posedge clk);
        rd(tap_pkg::REG_MISC, {lvl[5:1], 1'b1, 2'h0}, tap_pkg::RESP_OKAY);
        rd(tap_pkg::REG_MISC, {lvl[5:1], 1'b0, 2'h0}, tap_pkg::RESP_OKAY);
        rd(tap_pkg::REG_IRQ_ST, 8'h06, tap_pkg::RESP_OKAY);
        $display("test sense inputs done");
        close_out();
    end

endmodule : tb_table_access_port_status
